// ===== cpp_cmd_parser.sv
// Design decisions made here: the APB slave port and the placing of the registers.
`timescale 1ns/1ps
module cpp_cmd_parser (
   // Clock and reset
   input wire logic pclk,
   input wire logic presetn,
   // APB slave
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [11:0] paddr,
   input wire logic [31:0] pwdata,
   output logic [31:0] prdata,
   output logic pready,
   output logic pslverr,
   // Front panel keys, raw pins
   input wire logic key_local_raw,
   input wire logic key_opstby_raw,
   // Event status summary from status logic
   input wire logic event_summary,
   // Instrument controls
   output logic remote,
   output logic lockout,
   output logic standby,
   output logic output_enable,
   output logic [1:0] display_mode,
   output logic [3:0] pressure_unit,
   output logic [2:0] range_code,
   output logic signed [31:0] setpoint,
   output logic [2:0] setpoint_unit,
   output logic sensor_mode,
   output logic [7:0] sensor_type,
   output logic temp_fahrenheit,
   output logic cj_external,
   output logic service_request
);
   import cpp_pkg::*;

   function automatic logic addr_ok(input logic [11:0] a);
      addr_ok = (a == A_CMD) || (a == A_SETPOINT) || (a == A_RESP) ||
         (a == A_STATUS) || (a == A_CONFIG) || (a == A_STB) || (a == A_SRE);
   endfunction : addr_ok

   function automatic logic sensor_ok(input logic [7:0] c);
      sensor_ok = (c <= SNS_PLAT) ||
         ((c >= SNS_USR_FIRST) && (c <= SNS_USR_LAST));
   endfunction : sensor_ok

   function automatic logic is_temp(input logic [2:0] u);
      is_temp = (u == OU_DEGC) || (u == OU_DEGF);
   endfunction : is_temp

   cpp_state_e state_q;
   logic [CNT_W-1:0] rst_cnt_q;
   logic [CNT_W-1:0] settle_cnt_q;
   logic cmd_pend_q;
   logic [7:0] cmd_op_q;
   logic [7:0] cmd_par_q;
   logic signed [31:0] stage_q;
   logic [7:0] resp_code_q;
   logic resp_valid_q;
   logic cmd_error_q;
   logic hold_q;
   logic [2:0] held_range_q;
   logic [7:0] sre_q;
   logic [31:0] prdata_q;
   logic [1:0] keys_sync;
   logic [1:0] keys_prev_q;
   logic [2:0] auto_range;
   logic [7:0] stb;
   logic [7:0] resp_d;
   logic is_query;
   logic param_bad;
   logic op_bad;

   // APB decode
   logic setup_ph;
   logic access_ph;
   logic cmd_write;
   logic xfer;
   logic take;
   logic key_local_p;
   logic key_opstby_p;
   logic panel_locked;
   logic type_change;

   assign setup_ph = psel & ~penable;
   assign access_ph = psel & penable;
   assign cmd_write = access_ph & pwrite & (paddr == A_CMD);
   // Command slot full stalls the bus instead of dropping a command
   assign pready = ~(cmd_write & cmd_pend_q);
   assign pslverr = access_ph & ~addr_ok(paddr);
   assign xfer = access_ph & pready;
   assign prdata = prdata_q;
   // Single executor, no knowledge of which port wrote the slot
   assign take = cmd_pend_q & (state_q == ST_IDLE);

   cpp_sync #(.W(2)) u_key_sync (
      .pclk(pclk),
      .presetn(presetn),
      .async_in({key_local_raw, key_opstby_raw}),
      .sync_out(keys_sync)
   );

   cpp_range_sel u_range (
      .value_uv(setpoint),
      .range_code(auto_range)
   );

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         keys_prev_q <= 2'h0;
      end else begin
         keys_prev_q <= keys_sync;
      end
   end

   assign key_local_p = keys_sync[1] & ~keys_prev_q[1];
   assign key_opstby_p = keys_sync[0] & ~keys_prev_q[0];
   assign panel_locked = remote & lockout;
   assign type_change = take & (cmd_op_q == OP_STYPE) & sensor_ok(cmd_par_q) &
      (cmd_par_q != sensor_type);

   // Command slot
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         cmd_pend_q <= 1'b0;
         cmd_op_q <= 8'h00;
         cmd_par_q <= 8'h00;
      end else if (xfer & cmd_write) begin
         cmd_pend_q <= 1'b1;
         cmd_op_q <= pwdata[7:0];
         cmd_par_q <= pwdata[15:8];
      end else if (take) begin
         cmd_pend_q <= 1'b0;
      end
   end

   // Executor sequencing
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         state_q <= ST_IDLE;
         rst_cnt_q <= '0;
      end else begin
         unique case (state_q)
            ST_IDLE: begin
               if (take && cmd_op_q == OP_RST) begin
                  state_q <= ST_RESET;
                  rst_cnt_q <= CNT_W'(RST_CYC - 1);
               end else if (take && cmd_op_q == OP_WAI) begin
                  state_q <= ST_WAIT;
               end
            end
            ST_RESET: begin
               if (rst_cnt_q == '0) begin
                  state_q <= ST_IDLE;
               end else begin
                  rst_cnt_q <= rst_cnt_q - 1'b1;
               end
            end
            ST_WAIT: begin
               if (settle_cnt_q == '0) begin
                  state_q <= ST_IDLE;
               end
            end
            default: begin
               state_q <= ST_IDLE;
            end
         endcase
      end
   end

   // Overlapped output settling
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         settle_cnt_q <= '0;
      end else if ((take && cmd_op_q == OP_OUT) || type_change) begin
         settle_cnt_q <= CNT_W'(SETTLE_CYC - 1);
      end else if (settle_cnt_q != '0) begin
         settle_cnt_q <= settle_cnt_q - 1'b1;
      end
   end

   // Remote and lockout; only power-up or the local command ends lockout
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         remote <= 1'b0;
         lockout <= 1'b0;
      end else if (take && cmd_op_q == OP_LOCAL) begin
         remote <= 1'b0;
         lockout <= 1'b0;
      end else if (take && cmd_op_q == OP_REMOTE) begin
         remote <= 1'b1;
      end else if (take && cmd_op_q == OP_LOCKOUT) begin
         lockout <= 1'b1;
      end else if (key_local_p && remote && !panel_locked) begin
         remote <= 1'b0;
      end
   end

   // Operate/standby
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         standby <= 1'b1;
      end else if (take && (cmd_op_q == OP_STBY || cmd_op_q == OP_RST)) begin
         standby <= 1'b1;
      end else if (take && cmd_op_q == OP_OPER) begin
         standby <= 1'b0;
      end else if (key_opstby_p && !remote) begin
         standby <= ~standby;
      end
   end

   assign output_enable = ~standby & ~((display_mode == DISP_SOURCE) &
      (sensor_mode == SMODE_RTD) & (sensor_type == SNS_PLAT) &
      is_temp(setpoint_unit));

   // Staged output value, applied by the output command
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         stage_q <= '0;
      end else if (xfer && pwrite && paddr == A_SETPOINT) begin
         stage_q <= pwdata;
      end
   end

   // Setpoint and its unit
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         setpoint <= '0;
         setpoint_unit <= OU_V;
      end else if (take && cmd_op_q == OP_RST) begin
         setpoint <= '0;
         setpoint_unit <= OU_V;
      end else if (type_change) begin
         setpoint <= '0;
         setpoint_unit <= OU_DEGC;
      end else if (take && cmd_op_q == OP_OUT) begin
         setpoint <= stage_q;
         if (cmd_par_q <= 8'(OU_DEGF)) begin
            setpoint_unit <= cmd_par_q[2:0];
         end
      end
   end

   // Primary display mode and temperature unit
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         display_mode <= DISP_SOURCE;
         temp_fahrenheit <= 1'b0;
      end else if (take) begin
         unique case (cmd_op_q)
            OP_PRESS: display_mode <= DISP_PRESSURE;
            OP_OHM_MSR, OP_THC_MSR: begin
               display_mode <= (cmd_op_q == OP_OHM_MSR) ? DISP_RTD : DISP_TC;
               if (cmd_par_q == TUNIT_C || cmd_par_q == TUNIT_F) begin
                  temp_fahrenheit <= cmd_par_q[0];
               end
            end
            OP_OUT, OP_RST: display_mode <= DISP_SOURCE;
            default: begin
            end
         endcase
      end
   end

   // Pressure unit, sensor mode and type survive a reset
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         pressure_unit <= PUNIT_RESET;
         sensor_mode <= SMODE_RTD;
         sensor_type <= SNS_RESET;
      end else if (take) begin
         if (cmd_op_q == OP_PUNIT && cmd_par_q <= PUNIT_LAST) begin
            pressure_unit <= cmd_par_q[3:0];
         end
         if (cmd_op_q == OP_SMODE) begin
            sensor_mode <= cmd_par_q[0];
         end
         if (cmd_op_q == OP_STYPE && sensor_ok(cmd_par_q)) begin
            sensor_type <= cmd_par_q;
         end
      end
   end

   // Range hold
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         hold_q <= 1'b0;
         held_range_q <= RNG_V0P1;
      end else if (take && cmd_op_q == OP_RST) begin
         hold_q <= 1'b0;
         held_range_q <= RNG_V0P1;
      end else if (take && cmd_op_q == OP_HOLD && cmd_par_q == CODE_ON) begin
         hold_q <= 1'b1;
         held_range_q <= auto_range;
      end else if (take && cmd_op_q == OP_HOLD && cmd_par_q == CODE_OFF) begin
         hold_q <= 1'b0;
      end
   end

   always_comb begin
      if (setpoint_unit == OU_V) begin
         range_code = hold_q ? held_range_q : auto_range;
      end else if (setpoint_unit == OU_A) begin
         range_code = RNG_A0P1;
      end else begin
         range_code = RNG_NONE;
      end
   end

   // Cold-junction source
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         cj_external <= 1'b0;
      end else if (take && cmd_op_q == OP_RST) begin
         cj_external <= 1'b0;
      end else if (take && cmd_op_q == OP_CJ && cmd_par_q <= CODE_EXT) begin
         cj_external <= cmd_par_q[0];
      end
   end

   // Service request enable; bit 6 never stored
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         sre_q <= 8'h00;
      end else if (take && cmd_op_q == OP_SRE && !cmd_par_q[SRE_UNUSED]) begin
         sre_q <= cmd_par_q & ~(8'h01 << SRE_UNUSED);
      end
   end

   // Status byte
   always_comb begin
      stb = 8'h00;
      stb[STB_MAV] = resp_valid_q;
      stb[STB_ESB] = event_summary;
      stb[STB_MSS] = |(stb & sre_q);
   end

   assign service_request = stb[STB_MSS];

   // Query answers and command checking
   always_comb begin
      resp_d = 8'h00;
      is_query = 1'b1;
      op_bad = 1'b0;
      param_bad = 1'b0;
      unique case (cmd_op_q)
         OP_PUNIT_Q: resp_d = {4'h0, pressure_unit};
         OP_RANGE_Q: resp_d = {5'h00, range_code};
         OP_HOLD_Q: resp_d = hold_q ? CODE_ON : CODE_OFF;
         OP_STYPE_Q: resp_d = sensor_type;
         OP_SRE_Q: resp_d = sre_q;
         OP_STB_Q: resp_d = stb;
         OP_CJ_Q: resp_d = cj_external ? CODE_EXT : CODE_INT;
         default: begin
            is_query = 1'b0;
            unique case (cmd_op_q)
               OP_PUNIT: param_bad = cmd_par_q > PUNIT_LAST;
               OP_HOLD: param_bad = cmd_par_q > CODE_ON;
               OP_STYPE: param_bad = !sensor_ok(cmd_par_q);
               OP_CJ: param_bad = cmd_par_q > CODE_EXT;
               OP_SRE: param_bad = cmd_par_q[SRE_UNUSED];
               OP_PRESS, OP_REMOTE, OP_LOCAL, OP_LOCKOUT, OP_RST,
               OP_OHM_MSR, OP_THC_MSR, OP_STBY, OP_OPER, OP_WAI, OP_OUT,
               OP_SMODE: param_bad = 1'b0;
               default: op_bad = 1'b1;
            endcase
         end
      endcase
   end

   // Response register; answer set wins, clear needs a read that saw it
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         resp_code_q <= 8'h00;
         resp_valid_q <= 1'b0;
      end else if (take && is_query) begin
         resp_code_q <= resp_d;
         resp_valid_q <= 1'b1;
      end else if (xfer && !pwrite && paddr == A_RESP && prdata_q[RESP_VALID]) begin
         resp_valid_q <= 1'b0;
      end
   end

   // Sticky command error, write one to STATUS bit to clear
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         cmd_error_q <= 1'b0;
      end else if (take && (op_bad || param_bad)) begin
         cmd_error_q <= 1'b1;
      end else if (xfer && pwrite && paddr == A_STATUS && pwdata[ST_ERROR]) begin
         cmd_error_q <= 1'b0;
      end
   end

   // Read data captured in the setup phase
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         prdata_q <= 32'h0000_0000;
      end else if (setup_ph && !pwrite) begin
         prdata_q <= 32'h0000_0000;
         unique case (paddr)
            A_CMD: prdata_q <= {16'h0000, cmd_par_q, cmd_op_q};
            A_SETPOINT: prdata_q <= stage_q;
            A_RESP: prdata_q <= {23'h000000, resp_valid_q, resp_code_q};
            A_STATUS: begin
               prdata_q[ST_REMOTE] <= remote;
               prdata_q[ST_LOCKOUT] <= lockout;
               prdata_q[ST_STANDBY] <= standby;
               prdata_q[ST_BUSY] <= cmd_pend_q | (state_q != ST_IDLE);
               prdata_q[ST_ERROR] <= cmd_error_q;
               prdata_q[ST_HOLD] <= hold_q;
               prdata_q[ST_CJ_EXT] <= cj_external;
            end
            A_CONFIG: prdata_q <= {12'h000, temp_fahrenheit, sensor_mode,
               display_mode, sensor_type, range_code, 1'b0, pressure_unit};
            A_STB: prdata_q <= {24'h000000, stb};
            A_SRE: prdata_q <= {24'h000000, sre_q};
            default: prdata_q <= 32'h0000_0000;
         endcase
      end
   end
endmodule : cpp_cmd_parser

// ===== cpp_pkg.sv
package cpp_pkg;
   // Timing
   localparam int CLK_PERIOD_NS = 10;
   localparam int RST_TIME_NS = 2000;
   localparam int RST_CYC = (RST_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
   localparam int SETTLE_TIME_NS = 10000;
   localparam int SETTLE_CYC = (SETTLE_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
   localparam int CNT_W = 11;

   // Register byte offsets
   localparam logic [11:0] A_CMD = 12'h000;
   localparam logic [11:0] A_SETPOINT = 12'h004;
   localparam logic [11:0] A_RESP = 12'h008;
   localparam logic [11:0] A_STATUS = 12'h00C;
   localparam logic [11:0] A_CONFIG = 12'h010;
   localparam logic [11:0] A_STB = 12'h014;
   localparam logic [11:0] A_SRE = 12'h018;

   // Opcodes, written to CMD[7:0], parameter in CMD[15:8]
   localparam logic [7:0] OP_PRESS = 8'h01;
   localparam logic [7:0] OP_PUNIT = 8'h02;
   localparam logic [7:0] OP_PUNIT_Q = 8'h03;
   localparam logic [7:0] OP_RANGE_Q = 8'h04;
   localparam logic [7:0] OP_HOLD = 8'h05;
   localparam logic [7:0] OP_HOLD_Q = 8'h06;
   localparam logic [7:0] OP_REMOTE = 8'h07;
   localparam logic [7:0] OP_LOCAL = 8'h08;
   localparam logic [7:0] OP_LOCKOUT = 8'h09;
   localparam logic [7:0] OP_RST = 8'h0A;
   localparam logic [7:0] OP_OHM_MSR = 8'h0B;
   localparam logic [7:0] OP_STYPE = 8'h0C;
   localparam logic [7:0] OP_STYPE_Q = 8'h0D;
   localparam logic [7:0] OP_SRE = 8'h0E;
   localparam logic [7:0] OP_SRE_Q = 8'h0F;
   localparam logic [7:0] OP_STB_Q = 8'h10;
   localparam logic [7:0] OP_STBY = 8'h11;
   localparam logic [7:0] OP_OPER = 8'h12;
   localparam logic [7:0] OP_THC_MSR = 8'h13;
   localparam logic [7:0] OP_CJ = 8'h14;
   localparam logic [7:0] OP_CJ_Q = 8'h15;
   localparam logic [7:0] OP_WAI = 8'h16;
   localparam logic [7:0] OP_OUT = 8'h17;
   localparam logic [7:0] OP_SMODE = 8'h18;

   // Parameter and response codes
   localparam logic [7:0] CODE_OFF = 8'h00;
   localparam logic [7:0] CODE_ON = 8'h01;
   localparam logic [7:0] CODE_INT = 8'h00;
   localparam logic [7:0] CODE_EXT = 8'h01;
   localparam logic [7:0] TUNIT_C = 8'h00;
   localparam logic [7:0] TUNIT_F = 8'h01;
   localparam logic [7:0] PUNIT_LAST = 8'h0E;
   localparam logic [7:0] SNS_FIXED_LAST = 8'h0F;
   localparam logic [7:0] SNS_OHMS_LOW = 8'h11;
   localparam logic [7:0] SNS_PLAT = 8'h12;
   localparam logic [7:0] SNS_USR_FIRST = 8'h21;
   localparam logic [7:0] SNS_USR_LAST = 8'h25;
   localparam logic [7:0] SNS_RESET = 8'h00;
   localparam logic [3:0] PUNIT_RESET = 4'h0;
   localparam logic SMODE_TC = 1'b0;
   localparam logic SMODE_RTD = 1'b1;

   // Range codes and thresholds in microvolts
   localparam logic [2:0] RNG_V0P1 = 3'h0;
   localparam logic [2:0] RNG_V1 = 3'h1;
   localparam logic [2:0] RNG_V10 = 3'h2;
   localparam logic [2:0] RNG_V100 = 3'h3;
   localparam logic [2:0] RNG_A0P1 = 3'h4;
   localparam logic [2:0] RNG_NONE = 3'h5;
   localparam logic [31:0] LIM_V0P1 = 32'h0001_86A0;
   localparam logic [31:0] LIM_V1 = 32'h000F_4240;
   localparam logic [31:0] LIM_V10 = 32'h0098_9680;

   // Status byte and enable positions
   localparam int SRE_UNUSED = 6;
   localparam int STB_MAV = 4;
   localparam int STB_ESB = 5;
   localparam int STB_MSS = 6;

   // STATUS register bits, and the valid bit of the RESP register
   localparam int ST_REMOTE = 0;
   localparam int ST_LOCKOUT = 1;
   localparam int ST_STANDBY = 2;
   localparam int ST_BUSY = 3;
   localparam int ST_ERROR = 4;
   localparam int ST_HOLD = 5;
   localparam int ST_CJ_EXT = 6;
   localparam int RESP_VALID = 8;

   typedef enum logic [1:0] {
      ST_IDLE = 2'b00,
      ST_RESET = 2'b01,
      ST_WAIT = 2'b10
   } cpp_state_e;

   typedef enum logic [1:0] {
      DISP_SOURCE = 2'b00,
      DISP_PRESSURE = 2'b01,
      DISP_RTD = 2'b10,
      DISP_TC = 2'b11
   } cpp_disp_e;

   typedef enum logic [2:0] {
      OU_V = 3'b000,
      OU_A = 3'b001,
      OU_OHM = 3'b010,
      OU_DEGC = 3'b011,
      OU_DEGF = 3'b100
   } cpp_unit_e;
endpackage : cpp_pkg

// ===== cpp_sync.sv
`timescale 1ns/1ps
module cpp_sync #(
   parameter int W = 2
) (
   // Clock and reset
   input wire logic pclk,
   input wire logic presetn,
   // Data
   input wire logic [W-1:0] async_in,
   output logic [W-1:0] sync_out
);
   logic [W-1:0] meta_q;

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         meta_q <= '0;
         sync_out <= '0;
      end else begin
         meta_q <= async_in;
         sync_out <= meta_q;
      end
   end
endmodule : cpp_sync

// ===== cpp_range_sel.sv
`timescale 1ns/1ps
module cpp_range_sel (
   // Output value in microvolts
   input wire logic signed [31:0] value_uv,
   // Smallest voltage range that holds it
   output logic [2:0] range_code
);
   import cpp_pkg::*;

   logic [31:0] mag;

   always_comb begin
      mag = value_uv[31] ? 32'(-value_uv) : 32'(value_uv);
      if (mag <= LIM_V0P1) begin
         range_code = RNG_V0P1;
      end else if (mag <= LIM_V1) begin
         range_code = RNG_V1;
      end else if (mag <= LIM_V10) begin
         range_code = RNG_V10;
      end else begin
         range_code = RNG_V100;
      end
   end
endmodule : cpp_range_sel

// ===== cpp_panel_model.sv
`timescale 1ns/1ps
module cpp_panel_model (
   // Clock
   input wire logic pclk,
   // Key pins
   output logic key_local_raw,
   output logic key_opstby_raw
);
   initial begin
      key_local_raw = 1'b0;
      key_opstby_raw = 1'b0;
   end
   // Held four cycles so the two-flop sync sees it
   task automatic press(input logic opstby);
      @(posedge pclk);
      if (opstby) key_opstby_raw <= 1'b1;
      else key_local_raw <= 1'b1;
      repeat (4) @(posedge pclk);
      key_opstby_raw <= 1'b0;
      key_local_raw <= 1'b0;
      repeat (4) @(posedge pclk);
      #1;
   endtask : press
endmodule : cpp_panel_model

// ===== cpp_parser_asserts.sv
`timescale 1ns/1ps
module cpp_parser_chk
   import cpp_pkg::*;
(
   // Clock and reset
   input wire logic pclk,
   input wire logic presetn,
   // Bus
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [11:0] paddr,
   input wire logic pready,
   // Controls
   input wire logic remote,
   input wire logic lockout,
   input wire logic standby,
   input wire logic output_enable,
   input wire logic [1:0] display_mode,
   input wire logic [3:0] pressure_unit,
   input wire logic [2:0] range_code,
   input wire logic signed [31:0] setpoint,
   input wire logic [2:0] setpoint_unit,
   input wire logic sensor_mode,
   input wire logic [7:0] sensor_type
);
   default clocking @(posedge pclk); endclocking
   default disable iff (!presetn);
   AST_RDY: assert property (!pready |-> psel && penable && pwrite && paddr == A_CMD)
      else $error("stall outside command write");
   AST_OE: assert property (output_enable |-> !standby)
      else $error("output live in standby");
   AST_SRC: assert property (sensor_mode && sensor_type == SNS_PLAT && display_mode == DISP_SOURCE
      && setpoint_unit inside {OU_DEGC, OU_DEGF} |-> !output_enable)
      else $error("platinum type sourcing");
   AST_RNG: assert property (range_code <= RNG_NONE)
      else $error("range code out of set");
   AST_NONE: assert property (setpoint_unit > OU_A |-> range_code == RNG_NONE)
      else $error("range not none");
   AST_AMP: assert property (setpoint_unit == OU_A |-> range_code == RNG_A0P1)
      else $error("current range wrong");
   AST_PU: assert property (pressure_unit <= 4'hE)
      else $error("pressure unit out of set");
   AST_TYPE: assert property (sensor_type <= 8'h12 || sensor_type inside {[8'h21:8'h25]})
      else $error("sensor type out of set");
   AST_ZERO: assert property ($changed(sensor_type) |-> setpoint == 32'h0)
      else $error("setpoint not zeroed");
   AST_LOCAL: assert property ($fell(remote) |-> !lockout)
      else $error("lockout kept after local");
endmodule : cpp_parser_chk
bind cpp_cmd_parser cpp_parser_chk u_chk (.pclk, .presetn, .psel, .penable, .pwrite, .paddr,
   .pready, .remote, .lockout, .standby, .output_enable, .display_mode, .pressure_unit,
   .range_code, .setpoint, .setpoint_unit, .sensor_mode, .sensor_type);

// ===== tb_calibrator_remote_command_parser.sv
`timescale 1ns/1ps
module tb_calibrator_remote_command_parser;
   import cpp_pkg::*;
   logic pclk = 1'b0, presetn = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0, evs = 1'b0;
   logic [11:0] paddr = 12'h000;
   logic [31:0] pwdata = 32'h0, prdata, r, setpoint;
   logic pready, remote, lockout, standby, oe, fahr, cj, srq, smode, slverr, se;
   logic [1:0] disp;
   logic [2:0] rng, sunit;
   logic [3:0] punit;
   logic [7:0] stype;
   logic [7:0] types [5] = '{8'h10, 8'h11, 8'h21, 8'h25, 8'h12};
   wire kl, ko;
   int err_count = 0, tests_run = 0, cyc = 0, t0;
   cpp_cmd_parser u_dut (.pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata,
      .prdata, .pready, .pslverr(slverr), .key_local_raw(kl), .key_opstby_raw(ko),
      .event_summary(evs), .remote, .lockout, .standby, .output_enable(oe),
      .display_mode(disp), .pressure_unit(punit), .range_code(rng), .setpoint,
      .setpoint_unit(sunit), .sensor_mode(smode), .sensor_type(stype), .temp_fahrenheit(fahr),
      .cj_external(cj), .service_request(srq));
   cpp_panel_model u_panel (.pclk(pclk), .key_local_raw(kl), .key_opstby_raw(ko));
   initial forever #5 pclk = ~pclk;
   task automatic summarize;
      $display("errors %0d checks %0d", err_count, tests_run);
      if (err_count == 0 && tests_run > 0) $display("All checks passed");
      else $display("Checks failed");
      $finish;
   endtask : summarize
   always @(posedge pclk) begin
      cyc <= cyc + 1;
      if (cyc == 40000) begin
         err_count++;
         summarize();
      end
   end
   task automatic chk(input string n, input logic [31:0] got, exp);
      tests_run++;
      if (got !== exp) begin
         err_count++;
         $display("mismatch %s exp %0h got %0h", n, exp, got);
      end
   endtask : chk
   // Request held until pready is seen high at a rising edge
   task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
      @(posedge pclk);
      psel <= 1'b1;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge pclk);
      penable <= 1'b1;
      @(posedge pclk);
      while (pready !== 1'b1) @(posedge pclk);
      r = prdata;
      se = slverr;
      psel <= 1'b0;
      penable <= 1'b0;
   endtask : apb
   task automatic cmd(input logic [7:0] op, p);
      apb(1'b1, A_CMD, {16'h0000, p, op});
      repeat (2) @(posedge pclk);
      #1;
   endtask : cmd
   task automatic q(input logic [7:0] op, e);
      cmd(op, 8'h00);
      r = 32'h0;
      while (r[RESP_VALID] !== 1'b1) apb(1'b0, A_RESP, 32'h0);
      chk("resp", r[8:0], {1'b1, e});
   endtask : q
   task automatic errchk(input logic e);
      apb(1'b0, A_STATUS, 32'h0);
      chk("err", r[ST_ERROR], e);
      apb(1'b1, A_STATUS, 32'h0000_0010);
   endtask : errchk
   initial begin
      repeat (2) @(posedge pclk);
      presetn <= 1'b1;
      #1;
      chk("rst", {remote, lockout, standby, oe, rng}, 7'h10);
      cmd(OP_PRESS, 8'h00);
      chk("disp", disp, DISP_PRESSURE);
      for (int i = 0; i < 15; i++) begin
         cmd(OP_PUNIT, 8'(i));
         q(OP_PUNIT_Q, 8'(i));
      end
      cmd(OP_PUNIT, 8'h0F);
      errchk(1'b1);
      chk("punit", punit, 4'hE);
      cmd(OP_OHM_MSR, TUNIT_F);
      chk("rtd", {disp, fahr}, {DISP_RTD, 1'b1});
      cmd(OP_THC_MSR, 8'h02);
      chk("tc", {disp, fahr}, {DISP_TC, 1'b1});
      cmd(OP_THC_MSR, TUNIT_C);
      chk("tc", {disp, fahr}, {DISP_TC, 1'b0});
      cmd(OP_OHM_MSR, 8'h02);
      chk("rtd", {disp, fahr}, {DISP_RTD, 1'b0});
      apb(1'b1, A_SETPOINT, 32'h004C_4B40);
      cmd(OP_OUT, 8'h00);
      chk("rng", rng, RNG_V10);
      cmd(OP_HOLD, CODE_ON);
      q(OP_HOLD_Q, CODE_ON);
      apb(1'b1, A_SETPOINT, 32'h0000_C350);
      cmd(OP_OUT, 8'h00);
      q(OP_RANGE_Q, {5'h00, RNG_V10});
      cmd(OP_HOLD, CODE_OFF);
      q(OP_HOLD_Q, CODE_OFF);
      chk("rng", rng, RNG_V0P1);
      cmd(OP_OUT, 8'h01);
      q(OP_RANGE_Q, {5'h00, RNG_A0P1});
      cmd(OP_REMOTE, 8'h00);
      u_panel.press(1'b1);
      chk("rem", {remote, standby}, 2'b11);
      u_panel.press(1'b0);
      chk("rem", remote, 1'b0);
      u_panel.press(1'b1);
      chk("stby", standby, 1'b0);
      u_panel.press(1'b1);
      cmd(OP_REMOTE, 8'h00);
      cmd(OP_LOCKOUT, 8'h00);
      u_panel.press(1'b0);
      u_panel.press(1'b1);
      chk("lock", {remote, lockout, standby}, 3'b111);
      cmd(OP_LOCAL, 8'h00);
      chk("lock", {remote, lockout}, 2'b00);
      cmd(OP_PUNIT, 8'h03);
      cmd(OP_CJ, CODE_EXT);
      q(OP_CJ_Q, CODE_EXT);
      chk("cj", cj, 1'b1);
      cmd(OP_OPER, 8'h00);
      cmd(OP_RST, 8'h00);
      apb(1'b0, A_STATUS, 32'h0);
      chk("busy", r[ST_BUSY], 1'b1);
      q(OP_CJ_Q, CODE_INT);
      chk("rst", {standby, rng, punit, sunit}, {1'b1, RNG_V0P1, 4'h3, OU_V});
      chk("rst", setpoint, 32'h0);
      t0 = cyc;
      apb(1'b1, A_SETPOINT, 32'h004C_4B40);
      cmd(OP_OUT, 8'h00);
      cmd(OP_WAI, 8'h00);
      q(OP_HOLD_Q, CODE_OFF);
      chk("wait", cyc - t0 >= SETTLE_CYC, 1'b1);
      foreach (types[i]) begin
         apb(1'b1, A_SETPOINT, 32'h0000_0064);
         cmd(OP_OUT, 8'h00);
         cmd(OP_STYPE, types[i]);
         q(OP_STYPE_Q, types[i]);
         chk("zero", setpoint, 32'h0);
         chk("unit", sunit, OU_DEGC);
      end
      cmd(OP_OPER, 8'h00);
      chk("oe", oe, 1'b0);
      cmd(OP_SMODE, {7'h00, SMODE_TC});
      chk("mode", {smode, oe}, 2'b01);
      cmd(OP_SMODE, {7'h00, SMODE_RTD});
      cmd(OP_STYPE, SNS_USR_FIRST);
      chk("oe", oe, 1'b1);
      cmd(OP_STYPE, 8'h26);
      errchk(1'b1);
      cmd(OP_STBY, 8'h00);
      chk("stby", {standby, oe}, 2'b10);
      cmd(OP_SRE, 8'h30);
      cmd(OP_SRE, 8'hC0);
      errchk(1'b1);
      q(OP_SRE_Q, 8'h30);
      @(posedge pclk);
      evs <= 1'b1;
      @(posedge pclk);
      #1;
      chk("srq", srq, 1'b1);
      q(OP_STB_Q, 8'h60);
      apb(1'b0, 12'h01C, 32'h0);
      chk("slverr", se, 1'b1);
      summarize();
   end
endmodule : tb_calibrator_remote_command_parser
